// *** tcg_pkg.sv ***
package tcg_pkg;

    // Register word addresses; each 8-bit register takes one aligned 32-bit word.
    localparam logic [3:0] ADDR_COUNT_HIGH   = 4'h0;
    localparam logic [3:0] ADDR_COUNT_LOW    = 4'h1;
    localparam logic [3:0] ADDR_RELOAD_HIGH  = 4'h2;
    localparam logic [3:0] ADDR_RELOAD_LOW   = 4'h3;
    localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h4;
    localparam logic [3:0] ADDR_CAPTURE_LOW  = 4'h5;
    localparam logic [3:0] ADDR_CONTROL      = 4'h7;
    localparam logic [3:0] ADDR_STATUS       = 4'h8;

    // Control register fields; the output enable bit (CTRL_OUT_EN_BIT) lives in the status register.
    localparam int CTRL_ENABLE_BIT   = 7;
    localparam int CTRL_POLARITY_BIT = 6;
    localparam int CTRL_PRESCALE_LSB = 3;
    localparam int CTRL_MODE_LSB     = 0;
    localparam int CTRL_OUT_EN_BIT   = 0;

    // Reset values, and the count loaded on a restart (COUNT_RESTART).
    localparam logic [15:0] COUNT_RESET    = 16'h0001;
    localparam logic [15:0] RELOAD_RESET   = 16'hffff;
    localparam logic [15:0] CAPTURE_RESET  = 16'h0000;
    localparam logic [7:0]  CONTROL_RESET  = 8'h00;
    localparam logic [15:0] COUNT_RESTART  = 16'h0001;

    typedef enum logic [2:0]
    {
        TCG_MODE_CAPTURE  = 3'h0,
        TCG_MODE_COMPARE  = 3'h1,
        TCG_MODE_GATED    = 3'h2,
        TCG_MODE_CAPCMP   = 3'h3
    } tcg_mode_t;

endpackage

// *** tcg_prescale_if.sv ***
`timescale 1ns/10ps
interface tcg_prescale_if;
    logic       run;
    logic [2:0] shift;
    logic       tick;

    modport ctrl
    (
        output run,
        output shift,
        input  tick
    );
    modport div
    (
        input  run,
        input  shift,
        output tick
    );
endinterface

// *** tcg_prescaler.sv ***
`timescale 1ns/10ps
module tcg_prescaler
(
    input  wire logic  clock,
    input  wire logic  rst,
    tcg_prescale_if.div ps
);
    logic [6:0] div_ff;
    logic [6:0] limit;

    assign limit = 7'((8'h01 << ps.shift) - 8'h01);

    // The divider restarts whenever the timer stops, so each run begins on a full period.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            div_ff <= 7'h00;
        else if (!ps.run || div_ff >= limit)
            div_ff <= 7'h00;
        else
            div_ff <= div_ff + 7'h01;
    end

    assign ps.tick = ps.run && (div_ff >= limit);
endmodule

// *** tcg_timer.sv ***
`timescale 1ns/10ps
module tcg_timer
(
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic [3:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    input  wire logic                    timer_in,
    output logic                         timer_out,
    output logic                         timer_irq
);
    import tcg_pkg::*;

    logic [15:0] count_ff;
    logic [15:0] reload_ff;
    logic [15:0] capture_ff;
    logic [7:0]  reload_hold_ff;
    logic [7:0]  low_hold_ff;
    logic [7:0]  control_ff;
    logic        out_en_ff;
    logic        out_ff;
    logic        irq_ff;
    logic        armed_ff;
    logic        first_pass_ff;
    logic        in_meta_ff;
    logic        in_sync_ff;
    logic        in_prev_ff;
    logic        ack_ff;
    logic [31:0] rdata_ff;

    logic        enabled;
    logic        polarity;
    tcg_mode_t   mode;
    logic        tick;
    logic        edge_sel;
    logic        in_active;
    logic        in_leave;
    logic        at_reload;
    logic        wr_acc;
    logic        rd_acc;
    logic        rd_req;
    logic [7:0]  wbyte;
    logic        irq_event;
    logic        toggle_event;
    logic [15:0] nxt_count;

    tcg_prescale_if ps ();

    tcg_prescaler u_prescaler
    (
        .clock (clock),
        .rst   (rst),
        .ps    (ps.div)
    );

    assign enabled   = control_ff[CTRL_ENABLE_BIT];
    assign polarity  = control_ff[CTRL_POLARITY_BIT];
    assign mode      = tcg_mode_t'(control_ff[CTRL_MODE_LSB +: 3]);
    assign ps.run    = enabled;
    assign ps.shift  = control_ff[CTRL_PRESCALE_LSB +: 3];
    assign tick      = ps.tick;
    assign at_reload = (count_ff == reload_ff);

    // One-cycle answer: waitrequest is low in the cycle after a request is seen.
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    assign wr_acc          = avs_write && ack_ff;
    assign rd_acc          = avs_read && ack_ff;
    assign rd_req          = avs_read && !ack_ff;
    assign wbyte           = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
    assign avs_readdata    = rdata_ff;
    assign timer_out       = out_ff;
    assign timer_irq       = irq_ff;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            ack_ff <= 1'b0;
        else
            ack_ff <= (avs_read || avs_write) && !ack_ff;
    end

    // The pin is asynchronous; only the second and third stages feed edge and level logic.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            in_meta_ff <= 1'b0;
            in_sync_ff <= 1'b0;
            in_prev_ff <= 1'b0;
        end
        else
        begin
            in_meta_ff <= timer_in;
            in_sync_ff <= in_meta_ff;
            in_prev_ff <= in_sync_ff;
        end
    end

    assign edge_sel  = polarity ? (!in_sync_ff && in_prev_ff) : (in_sync_ff && !in_prev_ff);
    assign in_active = (in_sync_ff == polarity);
    assign in_leave  = (in_prev_ff == polarity) && (in_sync_ff != polarity);

    // Counter next value. Bus byte writes take priority over counting.
    always_comb
    begin
        nxt_count    = count_ff;
        irq_event    = 1'b0;
        toggle_event = 1'b0;
        if (enabled)
        begin
            unique case (mode)
                TCG_MODE_CAPTURE:
                begin
                    if (edge_sel)
                        irq_event = 1'b1;
                    if (tick)
                    begin
                        if (at_reload)
                            irq_event = 1'b1;
                        nxt_count = count_ff + 16'h0001;
                    end
                end
                TCG_MODE_COMPARE:
                begin
                    if (tick)
                    begin
                        if (at_reload)
                        begin
                            irq_event    = 1'b1;
                            toggle_event = 1'b1;
                        end
                        nxt_count = count_ff + 16'h0001;
                    end
                end
                TCG_MODE_GATED:
                begin
                    if (in_leave)
                        irq_event = 1'b1;
                    if (tick && in_active)
                    begin
                        if (at_reload)
                        begin
                            irq_event    = 1'b1;
                            toggle_event = 1'b1;
                            nxt_count    = COUNT_RESTART;
                        end
                        else
                            nxt_count = count_ff + 16'h0001;
                    end
                end
                TCG_MODE_CAPCMP:
                begin
                    if (armed_ff && edge_sel)
                    begin
                        irq_event = 1'b1;
                        nxt_count = COUNT_RESTART;
                    end
                    else if (armed_ff && tick)
                    begin
                        if (at_reload)
                        begin
                            irq_event    = 1'b1;
                            toggle_event = 1'b1;
                            nxt_count    = COUNT_RESTART;
                        end
                        else
                            nxt_count = count_ff + 16'h0001;
                    end
                end
                default:
                begin
                    nxt_count = count_ff;
                end
            endcase
        end
        if (wr_acc && avs_address == ADDR_COUNT_HIGH)
            nxt_count = {wbyte, nxt_count[7:0]};
        if (wr_acc && avs_address == ADDR_COUNT_LOW)
            nxt_count = {nxt_count[15:8], wbyte};
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            count_ff <= COUNT_RESET;
        else
            count_ff <= nxt_count;
    end

    // Capture/Compare waits for its first edge; disabling rearms that wait.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            armed_ff <= 1'b0;
        else if (!enabled || mode != TCG_MODE_CAPCMP)
            armed_ff <= 1'b0;
        else if (edge_sel)
            armed_ff <= 1'b1;
    end

    // Kept for software visibility of whether the programmed start count is still in use in gated mode.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            first_pass_ff <= 1'b1;
        else if (!enabled)
            first_pass_ff <= 1'b1;
        else if (toggle_event && mode == TCG_MODE_GATED)
            first_pass_ff <= 1'b0;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            capture_ff <= CAPTURE_RESET;
        else if (enabled && edge_sel
                 && (mode == TCG_MODE_CAPTURE || (mode == TCG_MODE_CAPCMP && armed_ff)))
            capture_ff <= count_ff;
        else if (wr_acc && avs_address == ADDR_CAPTURE_HIGH)
            capture_ff[15:8] <= wbyte;
        else if (wr_acc && avs_address == ADDR_CAPTURE_LOW)
            capture_ff[7:0] <= wbyte;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            reload_ff      <= RELOAD_RESET;
            reload_hold_ff <= RELOAD_RESET[15:8];
        end
        else if (wr_acc && avs_address == ADDR_RELOAD_HIGH)
            reload_hold_ff <= wbyte;
        else if (wr_acc && avs_address == ADDR_RELOAD_LOW)
            reload_ff <= {reload_hold_ff, wbyte};
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            control_ff <= CONTROL_RESET;
            out_en_ff  <= 1'b0;
        end
        else if (wr_acc && avs_address == ADDR_CONTROL)
            control_ff <= wbyte;
        else if (wr_acc && avs_address == ADDR_STATUS)
            out_en_ff <= wbyte[CTRL_OUT_EN_BIT];
    end

    // While disabled the output follows the polarity bit, giving its starting level.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            out_ff <= 1'b0;
        else if (!enabled)
            out_ff <= polarity;
        else if (toggle_event && out_en_ff)
            out_ff <= !out_ff;
    end

    // The interrupt is a one-cycle pulse towards an external interrupt controller.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            irq_ff <= 1'b0;
        else
            irq_ff <= irq_event;
    end

    // The low byte is held at the same edge that samples the high byte, so no carry can tear them.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            low_hold_ff <= COUNT_RESET[7:0];
        else if (rd_req && enabled && avs_address == ADDR_COUNT_HIGH)
            low_hold_ff <= count_ff[7:0];
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rdata_ff <= 32'h0000_0000;
        else if (avs_read && !ack_ff)
        begin
            unique case (avs_address)
                ADDR_COUNT_HIGH:   rdata_ff <= {24'h000000, count_ff[15:8]};
                ADDR_COUNT_LOW:    rdata_ff <= {24'h000000,
                                    enabled ? low_hold_ff : count_ff[7:0]};
                ADDR_RELOAD_HIGH:  rdata_ff <= {24'h000000, reload_ff[15:8]};
                ADDR_RELOAD_LOW:   rdata_ff <= {24'h000000, reload_ff[7:0]};
                ADDR_CAPTURE_HIGH: rdata_ff <= {24'h000000, capture_ff[15:8]};
                ADDR_CAPTURE_LOW:  rdata_ff <= {24'h000000, capture_ff[7:0]};
                ADDR_CONTROL:      rdata_ff <= {24'h000000, control_ff};
                ADDR_STATUS:       rdata_ff <= {24'h000000, 3'h0, armed_ff, first_pass_ff,
                                                in_sync_ff, out_ff, out_en_ff};
                default:           rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    a_capture_copy: assert property (@(posedge clock) disable iff (rst)
        enabled && mode == TCG_MODE_CAPTURE && edge_sel |=> capture_ff == $past(count_ff))
        else $error("capture did not copy the count");

    a_capture_irq: assert property (@(posedge clock) disable iff (rst)
        enabled && mode == TCG_MODE_CAPTURE && edge_sel && !wr_acc |=> timer_irq
            && (count_ff == $past(count_ff) || count_ff == $past(count_ff) + 16'h0001))
        else $error("capture gave no interrupt");

    a_compare_wrap: assert property (@(posedge clock) disable iff (rst)
        enabled && mode == TCG_MODE_COMPARE && tick && count_ff == 16'hffff && !wr_acc
            |=> count_ff == 16'h0000)
        else $error("compare mode did not wrap to zero");

    a_gated_hold: assert property (@(posedge clock) disable iff (rst)
        enabled && mode == TCG_MODE_GATED && !in_active && !wr_acc |=> $stable(count_ff))
        else $error("gated counter moved while input inactive");

    a_gated_leave: assert property (@(posedge clock) disable iff (rst)
        enabled && mode == TCG_MODE_GATED && in_leave |=> timer_irq)
        else $error("gated deassert gave no interrupt");

    a_gated_reload: assert property (@(posedge clock) disable iff (rst)
        enabled && mode == TCG_MODE_GATED && tick && in_active && at_reload && !wr_acc
            |=> count_ff == COUNT_RESTART && timer_irq)
        else $error("gated reload did not restart at one");

    sequence s_first_edge;
        enabled && mode == TCG_MODE_CAPCMP && !armed_ff && edge_sel;
    endsequence

    a_capcmp_first: assert property (@(posedge clock) disable iff (rst)
        s_first_edge |=> !timer_irq && armed_ff)
        else $error("first capture edge raised an interrupt");

    a_capcmp_edge: assert property (@(posedge clock) disable iff (rst)
        enabled && mode == TCG_MODE_CAPCMP && armed_ff && edge_sel && !wr_acc
            |=> count_ff == COUNT_RESTART && timer_irq && capture_ff == $past(count_ff))
        else $error("capture/compare edge failed to restart");

    a_reload_atomic: assert property (@(posedge clock) disable iff (rst)
        wr_acc && avs_address == ADDR_RELOAD_HIGH |=> $stable(reload_ff))
        else $error("reload high write was not held");

    a_low_hold: assert property (@(posedge clock) disable iff (rst)
        rd_req && enabled && avs_address == ADDR_COUNT_HIGH |=> low_hold_ff == $past(count_ff[7:0]))
        else $error("high read did not latch the low byte");
endmodule

// *** tcg_pin_model.sv ***
`timescale 1ns/10ps
module tcg_pin_model
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       in_level,
    input  wire logic       timer_out,
    output logic            timer_in,
    output logic [7:0]      out_toggles
);
    logic last_out_ff;

    // The input pin has no pull, so the model drives it at all times.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            timer_in <= 1'b0;
        else
            timer_in <= in_level;
    end

    // Sampled mid-cycle, so a toggle is never missed or counted twice.
    always_ff @(negedge clock)
    begin
        last_out_ff <= timer_out;
        if (rst)
            out_toggles <= 8'h00;
        else if (timer_out !== last_out_ff)
            out_toggles <= out_toggles + 8'h01;
    end
endmodule

// *** tb_timer_capture_compare_gated.sv ***
`timescale 1ns/10ps
module tb_timer_capture_compare_gated;
    import tcg_pkg::*;
    logic        clock;
    logic        rst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        timer_in;
    logic        timer_out;
    logic        timer_irq;
    logic        in_level;
    logic [7:0]  out_toggles;
    logic [7:0]  q;
    logic [7:0]  t0;
    logic [15:0] v1;
    logic [15:0] v2;
    logic        pol;
    logic [2:0]  pres;
    int          fail_count;
    int          num_checks;
    int          irq_count;
    int          cyc_now;
    int          n0;
    int          c1;
    int          c2;

    tcg_timer dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer_in(timer_in),
        .timer_out(timer_out), .timer_irq(timer_irq));
    tcg_pin_model pins (.clock(clock), .rst(rst), .in_level(in_level), .timer_out(timer_out),
        .timer_in(timer_in), .out_toggles(out_toggles));

    always #20 clock = ~clock;

    always @(negedge clock)
    begin
        cyc_now <= cyc_now + 1;
        if (timer_irq === 1'b1)
            irq_count <= irq_count + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic inrange(input int v, input int lo, input int hi);
        check({31'h0, (v >= lo && v <= hi)}, 32'h1);
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic timeout();
        fail_count++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        print_verdict();
    endtask

    // The request stands until the rising edge at which waitrequest is seen low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] r);
        int n;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
            if (n > 20)
                timeout();
        end
        while (avs_waitrequest !== 1'b0);
        r = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rdv(input logic [3:0] a, output logic [7:0] r);
        bus(1'b0, a, 8'h00, r);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] r;
        bus(1'b0, a, 8'h00, r);
        check({24'h0, r}, {24'h0, exp});
    endtask

    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        logic [7:0] h;
        logic [7:0] l;
        rdv(a, h);
        rdv(a + 4'h1, l);
        v = {h, l};
    endtask

    task automatic setup(input logic [7:0] ctl, input logic [15:0] cnt, input logic [15:0] rld);
        wr(ADDR_CONTROL, ctl);
        wr(ADDR_COUNT_HIGH, cnt[15:8]);
        wr(ADDR_COUNT_LOW, cnt[7:0]);
        wr(ADDR_RELOAD_HIGH, rld[15:8]);
        wr(ADDR_RELOAD_LOW, rld[7:0]);
        wr(ADDR_CAPTURE_HIGH, 8'h00);
        wr(ADDR_CAPTURE_LOW, 8'h00);
        wr(ADDR_CONTROL, ctl | 8'h80);
    endtask

    task automatic wait_irq(input int lim, output int c);
        int s;
        s = irq_count;
        c = 0;
        while (irq_count == s)
        begin
            @(negedge clock);
            c++;
            if (c > lim)
                timeout();
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic pin(input logic v);
        @(posedge clock);
        in_level <= v;
    endtask

    initial
    begin
        clock = 1'b0;
        rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h1;
        in_level = 1'b0;
        fail_count = 0;
        num_checks = 0;
        irq_count = 0;
        cyc_now = 0;
        idle(8);
        rst <= 1'b0;
        rdchk(ADDR_COUNT_HIGH, COUNT_RESET[15:8]);
        rdchk(ADDR_COUNT_LOW, COUNT_RESET[7:0]);
        rdchk(ADDR_RELOAD_LOW, 8'hff);
        rdchk(ADDR_CAPTURE_HIGH, 8'h00);
        rdchk(ADDR_CONTROL, 8'h00);
        rdchk(4'h6, 8'h00);
        check(timer_out, 1'b0);
        wr(ADDR_RELOAD_HIGH, 8'h12);
        rdchk(ADDR_RELOAD_HIGH, 8'hff);
        wr(ADDR_RELOAD_LOW, 8'h34);
        rdchk(ADDR_RELOAD_HIGH, 8'h12);
        rdchk(ADDR_RELOAD_LOW, 8'h34);
        rdchk(ADDR_COUNT_HIGH, 8'h00);
        wr(ADDR_COUNT_LOW, 8'h07);
        rdchk(ADDR_COUNT_LOW, 8'h07);
        wr(ADDR_STATUS, 8'h01);
        for (int k = 0; k < 2; k++)
        begin
            pres = 3'(2 * k);
            setup({2'b00, pres, TCG_MODE_COMPARE}, 16'h0001, 16'h0009);
            wait_irq(200, c1);
            // The first prescaled step comes one full divide period after enabling, as the divider restarts while disabled.
            inrange(c1, 7 << pres, (8 << pres) + 6);
            idle(2);
            check(timer_out, 1'b1);
            wr(ADDR_CONTROL, {2'b00, pres, TCG_MODE_COMPARE});
            rd16(ADDR_COUNT_HIGH, v1);
            inrange(v1, 16'h000a, 16'h0020);
        end
        setup({2'b00, 3'h0, TCG_MODE_COMPARE}, 16'hfff8, 16'h0004);
        wait_irq(40, c1);
        inrange(c1, 11, 18);
        rdv(ADDR_COUNT_HIGH, q);
        c1 = cyc_now;
        idle(20);
        rdv(ADDR_COUNT_LOW, v1[7:0]);
        v1[15:8] = q;
        rdv(ADDR_COUNT_HIGH, q);
        c2 = cyc_now;
        rdv(ADDR_COUNT_LOW, v2[7:0]);
        v2[15:8] = q;
        check(32'(v2 - v1), 32'(c2 - c1));
        wr(ADDR_COUNT_HIGH, 8'h40);
        rdchk(ADDR_COUNT_HIGH, 8'h40);
        for (int p = 0; p < 2; p++)
        begin
            pol = p[0];
            pin(~pol);
            setup({1'b0, pol, 3'h0, TCG_MODE_CAPTURE}, 16'h0001, 16'hffff);
            n0 = irq_count;
            idle(20);
            pin(pol);
            idle(20);
            check(irq_count, n0);
            rdchk(ADDR_CAPTURE_LOW, 8'h00);
            pin(~pol);
            c1 = cyc_now;
            wait_irq(10, c2);
            rd16(ADDR_CAPTURE_HIGH, v1);
            rdv(ADDR_COUNT_HIGH, q);
            c2 = cyc_now;
            rdv(ADDR_COUNT_LOW, v2[7:0]);
            v2[15:8] = q;
            inrange(int'(v2 - v1), c2 - c1 - 7, c2 - c1);
        end
        setup({2'b00, 3'h0, TCG_MODE_CAPTURE}, 16'h0001, 16'h0030);
        wait_irq(70, c1);
        inrange(c1, 46, 52);
        idle(10);
        rd16(ADDR_COUNT_HIGH, v1);
        inrange(v1, 16'h0031, 16'h0060);
        setup({2'b01, 3'h0, TCG_MODE_GATED}, 16'h0018, 16'h0020);
        idle(20);
        t0 = out_toggles;
        rd16(ADDR_COUNT_HIGH, v1);
        check(v1, 16'h0018);
        pin(1'b1);
        wait_irq(20, c1);
        inrange(c1, 7, 14);
        wait_irq(40, c2);
        inrange(c2, 30, 33);
        idle(2);
        check(out_toggles - t0, 8'h02);
        pin(1'b0);
        wait_irq(10, c1);
        rdv(ADDR_STATUS, q);
        check(q[2] == pol, 1'b0);
        rd16(ADDR_COUNT_HIGH, v1);
        idle(10);
        rd16(ADDR_COUNT_HIGH, v2);
        check(v2, v1);
        setup({2'b00, 3'h0, TCG_MODE_CAPCMP}, 16'h0001, 16'h0100);
        n0 = irq_count;
        idle(30);
        rd16(ADDR_COUNT_HIGH, v1);
        check(v1, 16'h0001);
        pin(1'b1);
        idle(10);
        check(irq_count, n0);
        idle(30);
        pin(1'b0);
        idle(5);
        pin(1'b1);
        wait_irq(10, c2);
        rd16(ADDR_CAPTURE_HIGH, v1);
        inrange(v1, 16'h0028, 16'h0040);
        rd16(ADDR_COUNT_HIGH, v2);
        inrange(v2, 16'h0001, 16'h0010);
        wait_irq(300, c1);
        rd16(ADDR_COUNT_HIGH, v1);
        inrange(v1, 16'h0001, 16'h0010);
        print_verdict();
    end
endmodule
